// *** src/rerc_regulator_enable_reset_control.sv ***
// Purpose: enable, soft start, discharge, power-good, reset
// Assumes: hysteresis analog; precharge steady
// Notes:   strobe port, read data one cycle later
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - bias delay before switching
// - soft start 5 to 95 percent in 750 us
// - precharge shortens ramp, no discharge
// - low headroom gives full duty
// - disabled converter discharged if enabled
// - discharge per converter, off after reset
// - five rails report low in status
// - any rail fault raises interrupt
// - disabled rail reads good
// - shared pin enables linear regulators, registers too
// - undervoltage or overheat stops all
// - lockout holds all off while supply low
// - own enable pin per converter
// - core default 1.3 V or 1.55 V by strap
// - memory default 1.8 V or 2.5 V by strap
// - system default 3 V or 3.3 V by strap
// - warm reset restores core default only
// - warm reset debounced, pulled up
// - reset low at power-up and backup low
// - hold time set by capacitor, 100 ms; here a counter of RESET_HOLD_CYC clock cycles
// - warm reset also forces processor reset low
// - warm reset stable 30 ms before accepted
// - hold starts on backup good; fall reasserts
module rerc_regulator_enable_reset_control #(
    parameter logic [23:0] RESET_HOLD_CYC = 24'(rerc_pkg::RESET_HOLD_CYC),
    parameter int          DEBOUNCE_CYC   = rerc_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // enable pins
    input  wire logic        systemConvEnable,
    input  wire logic        memoryConvEnable,
    input  wire logic        coreConvEnable,
    input  wire logic        linearRegEnable,
    // default-select straps
    input  wire logic        systemDefaultSelect,
    input  wire logic        memoryDefaultSelect,
    input  wire logic        coreDefaultSelect,
    // protection comparators
    input  wire logic        supplyUndervoltage,
    input  wire logic        overTemperature,
    input  wire logic        backupRailGood,
    // rail low monitors: sys, mem, core, lin1, lin2
    input  wire logic [4:0]  railBelowTarget,
    // headroom detectors: sys, mem, core
    input  wire logic [2:0]  dropoutDetect,
    // precharge level, ref units
    input  wire logic [7:0]  systemPrecharge,
    input  wire logic [7:0]  memoryPrecharge,
    input  wire logic [7:0]  corePrecharge,
    // warm reset pin
    input  wire logic        warmResetInN,
    output logic             warmResetPullupEn,
    // converter drive: sys, mem, core
    output logic [2:0]       convBiasOn,
    output logic [2:0]       convSwitchOn,
    output logic [2:0]       convLowSideBlock,
    output logic [2:0]       convFullDuty,
    output logic [2:0]       convDischarge,
    output logic [7:0]       systemSoftStartRef,
    output logic [7:0]       memorySoftStartRef,
    output logic [7:0]       coreSoftStartRef,
    // target voltages in millivolts
    output logic [11:0]      systemRail,
    output logic [11:0]      memoryRail,
    output logic [11:0]      coreRail,
    // linear regulators
    output logic [1:0]       linearRegOn,
    output logic [7:0]       linearRegVoltage,
    // status
    output logic             powerFaultIrq,
    // processor reset, open drain
    output logic             processorResetOutO,
    output logic             processorResetOutOe,
    // register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [15:0]      regRdata
);

    logic [rerc_pkg::PIN_COUNT-1:0] pinRaw;
    logic [rerc_pkg::PIN_COUNT-1:0] pinSync;
    logic                           warmLevel;
    logic                           warmActive;
    logic                           shutdown;
    logic [2:0]                     convEnable;
    logic [2:0][7:0]                prechargeIn;
    logic [2:0][7:0]                softRef;
    logic [2:0]                     convRunning;
    logic [4:0]                     railEnabled;
    logic [4:0]                     railFault;
    logic [11:0]                    coreDefault;

    // register state
    logic [2:0]                     dischargeEn_ff;
    logic [1:0]                     linearEn_ff;
    logic [7:0]                     linearVolt_ff;
    logic                           coreOverride_ff;
    logic [11:0]                    coreSet_ff;
    logic [15:0]                    regRdata_ff;
    logic [15:0]                    nxt_regRdata;

    // processor reset state
    logic                           resetAsserted_ff;
    logic [23:0]                    holdCnt_ff;
    logic                           resetCause;

    // pins gathered so one generate loop filters them all
    assign pinRaw = {coreDefaultSelect, memoryDefaultSelect, systemDefaultSelect,
                     dropoutDetect, railBelowTarget, backupRailGood,
                     overTemperature, supplyUndervoltage, linearRegEnable,
                     coreConvEnable, memoryConvEnable, systemConvEnable};

    // three-stage synchronisers; stages two and three must agree once, so a one-cycle glitch is dropped
    for (genvar p = 0; p < rerc_pkg::PIN_COUNT; p++) begin : g_pin
        rerc_pin_filter #(
            .STABLE_CYC (1),
            .INIT       (1'b0)
        ) u_sync (
            .clk    (clk),
            .rst_n  (rst_n),
            .pinIn  (pinRaw[p]),
            .pinOut (pinSync[p])
        );
    end

    // warm reset: long stability filter, idle level high
    rerc_pin_filter #(
        .STABLE_CYC (DEBOUNCE_CYC),
        .INIT       (1'b1)
    ) u_warm (
        .clk    (clk),
        .rst_n  (rst_n),
        .pinIn  (warmResetInN),
        .pinOut (warmLevel)
    );
    assign warmActive        = ~warmLevel;
    assign warmResetPullupEn = 1'b1;

    // protection shuts every regulator down
    assign shutdown = pinSync[rerc_pkg::PIN_UVLO] | pinSync[rerc_pkg::PIN_OVER_TEMPERATURE];

    // each converter follows its own pin unless protection holds it off
    assign convEnable = pinSync[rerc_pkg::PIN_CONV_LSB +: 3] & {3{~shutdown}};

    assign prechargeIn = {corePrecharge, memoryPrecharge, systemPrecharge};

    // per-converter start-up sequencer
    for (genvar c = 0; c < 3; c++) begin : g_conv
        rerc_pkg::rerc_conv_state_t state_ff;
        logic [15:0]                timer_ff;
        logic [7:0]                 ref_ff;
        logic [7:0]                 pre_ff;

        // sequence: off, bias wait, ramp, run; a disable always wins
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                state_ff <= rerc_pkg::CONV_OFF;
                timer_ff <= 16'h0000;
                ref_ff   <= 8'h00;
            end else if (!convEnable[c]) begin
                state_ff <= rerc_pkg::CONV_OFF;
                timer_ff <= 16'h0000;
                ref_ff   <= 8'h00;
            end else begin
                case (state_ff)
                    rerc_pkg::CONV_OFF: begin
                        state_ff <= rerc_pkg::CONV_BIAS;
                        timer_ff <= 16'h0000;
                    end
                    rerc_pkg::CONV_BIAS: begin
                        if (timer_ff == 16'(rerc_pkg::BIAS_CYC - 1)) begin
                            state_ff <= rerc_pkg::CONV_RAMP;
                            timer_ff <= 16'h0000;
                        end else begin
                            timer_ff <= timer_ff + 16'h0001;
                        end
                    end
                    rerc_pkg::CONV_RAMP: begin
                        if (ref_ff == 8'(rerc_pkg::REF_FULL)) begin
                            state_ff <= rerc_pkg::CONV_RUN;
                        end else if (ref_ff < pre_ff) begin
                            ref_ff <= ref_ff + 8'h01;
                        end else if (timer_ff == 16'(rerc_pkg::SS_STEP_CYC - 1)) begin
                            ref_ff   <= ref_ff + 8'h01;
                            timer_ff <= 16'h0000;
                        end else begin
                            timer_ff <= timer_ff + 16'h0001;
                        end
                    end
                    rerc_pkg::CONV_RUN: begin
                        ref_ff <= 8'(rerc_pkg::REF_FULL);
                    end
                    default: begin
                        state_ff <= rerc_pkg::CONV_OFF;
                    end
                endcase
            end
        end

        // precharge is sampled during bias, clipped to full scale
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pre_ff <= 8'h00;
            end else if (state_ff == rerc_pkg::CONV_BIAS) begin
                pre_ff <= (prechargeIn[c] > 8'(rerc_pkg::REF_FULL)) ?
                          8'(rerc_pkg::REF_FULL) : prechargeIn[c];
            end
        end

        assign convBiasOn[c]       = (state_ff != rerc_pkg::CONV_OFF);
        assign convSwitchOn[c]     = (state_ff == rerc_pkg::CONV_RAMP) |
                                     (state_ff == rerc_pkg::CONV_RUN);
        // the rectifier stays off until the reference reaches the output level
        assign convLowSideBlock[c] = (state_ff == rerc_pkg::CONV_RAMP) &
                                     (ref_ff < pre_ff);
        assign convFullDuty[c]     = (state_ff == rerc_pkg::CONV_RUN) &
                                     pinSync[rerc_pkg::PIN_DROP_LSB + c];
        assign convDischarge[c]    = (state_ff == rerc_pkg::CONV_OFF) &
                                     dischargeEn_ff[c];
        assign convRunning[c]      = (state_ff == rerc_pkg::CONV_RUN);
        assign softRef[c]          = ref_ff;
    end

    assign systemSoftStartRef = softRef[0];
    assign memorySoftStartRef = softRef[1];
    assign coreSoftStartRef   = softRef[2];

    // strap-selected defaults follow the pins, which are tied on the board
    assign systemRail  = pinSync[rerc_pkg::PIN_STRAP_LSB]     ?
                         rerc_pkg::SYSTEM_HI_MV : rerc_pkg::SYSTEM_LO_MV;
    assign memoryRail  = pinSync[rerc_pkg::PIN_STRAP_LSB + 1] ?
                         rerc_pkg::MEMORY_HI_MV : rerc_pkg::MEMORY_LO_MV;
    assign coreDefault = pinSync[rerc_pkg::PIN_STRAP_LSB + 2] ?
                         rerc_pkg::CORE_HI_MV : rerc_pkg::CORE_LO_MV;
    assign coreRail    = coreOverride_ff ? coreSet_ff : coreDefault;

    // linear regulators: shared pin and register enable, both gated by protection
    assign linearRegOn      = {2{pinSync[rerc_pkg::PIN_LINEAR_EN] & ~shutdown}} &
                              linearEn_ff;
    assign linearRegVoltage = linearVolt_ff;

    // monitors count only while the rail is enabled
    assign railEnabled = {linearRegOn, convBiasOn};
    assign railFault   = railEnabled & pinSync[rerc_pkg::PIN_LOW_LSB +: 5];
    assign powerFaultIrq = |railFault;

    // software settings, one register per write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dischargeEn_ff <= rerc_pkg::DISCHARGE_RST;
            linearEn_ff    <= rerc_pkg::LINEAR_EN_RST;
            linearVolt_ff  <= rerc_pkg::LINEAR_VOLT_RST;
        end else if (regWrite) begin
            if (regAddr == rerc_pkg::REG_CONVERTER_CONTROL_2) begin
                dischargeEn_ff <= regWdata[2:0];
            end
            if (regAddr == rerc_pkg::REG_LINEAR_REG_CONTROL) begin
                linearEn_ff <= regWdata[1:0];
            end
            if (regAddr == rerc_pkg::REG_LINEAR_REG_VOLTAGE) begin
                linearVolt_ff <= regWdata[7:0];
            end
        end
    end

    // core setting; warm reset wins over a write so the default is restored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            coreOverride_ff <= 1'b0;
            coreSet_ff      <= 12'h000;
        end else if (warmActive) begin
            coreOverride_ff <= 1'b0;
        end else if (regWrite && regAddr == rerc_pkg::REG_CORE_VOLTAGE) begin
            coreOverride_ff <= 1'b1;
            coreSet_ff      <= regWdata[11:0];
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        nxt_regRdata = 16'h0000;
        case (regAddr)
            rerc_pkg::REG_CONVERTER_CONTROL_2: nxt_regRdata[2:0]  = dischargeEn_ff;
            rerc_pkg::REG_LINEAR_REG_CONTROL:  nxt_regRdata[1:0]  = linearEn_ff;
            rerc_pkg::REG_LINEAR_REG_VOLTAGE:  nxt_regRdata[7:0]  = linearVolt_ff;
            rerc_pkg::REG_CORE_VOLTAGE:        nxt_regRdata[11:0] = coreRail;
            rerc_pkg::REG_POWER_GOOD_STATUS:   nxt_regRdata[4:0]  = railFault;
            rerc_pkg::REG_BLOCK_STATE: begin
                nxt_regRdata[rerc_pkg::ST_RUNNING_LSB +: 3] = convRunning;
                nxt_regRdata[rerc_pkg::ST_LINEAR_LSB +: 2]  = linearRegOn;
                nxt_regRdata[rerc_pkg::ST_SHUTDOWN_BIT]     = shutdown;
                nxt_regRdata[rerc_pkg::ST_RESET_BIT]        = resetAsserted_ff;
                nxt_regRdata[rerc_pkg::ST_WARM_BIT]         = warmActive;
            end
            default: nxt_regRdata = 16'h0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata_ff <= 16'h0000;
        end else if (regRead) begin
            regRdata_ff <= nxt_regRdata;
        end else begin
            regRdata_ff <= 16'h0000;
        end
    end
    assign regRdata = regRdata_ff;

    // reset causes: backup rail low or accepted warm reset
    assign resetCause = ~pinSync[rerc_pkg::PIN_BACKUP_GOOD] | warmActive;

    // hold timer restarts while any cause stands, so release is one full hold later
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resetAsserted_ff <= 1'b1;
            holdCnt_ff       <= 24'h000000;
        end else if (resetCause) begin
            resetAsserted_ff <= 1'b1;
            holdCnt_ff       <= 24'h000000;
        end else if (resetAsserted_ff) begin
            if (holdCnt_ff == RESET_HOLD_CYC - 24'h000001) begin
                resetAsserted_ff <= 1'b0;
                holdCnt_ff       <= 24'h000000;
            end else begin
                holdCnt_ff <= holdCnt_ff + 24'h000001;
            end
        end
    end

    // open drain: drive low while asserted, release otherwise
    assign processorResetOutO  = 1'b0;
    assign processorResetOutOe = resetAsserted_ff;

endmodule
`default_nettype wire

// *** src/rerc_pkg.sv ***
// Purpose: shared constants and types
// Assumes: 20 MHz clock; comparators give logic levels
// Notes:   times converted to cycles here
package rerc_pkg;

    // clock
    localparam int CLK_MHZ          = 20;

    // converter bias delay before switching, least time, rounded up
    localparam int BIAS_TIME_US     = 170;
    localparam int BIAS_CYC         = BIAS_TIME_US * CLK_MHZ;

    // soft start: reference runs 0..REF_FULL, 5 % to 95 % takes SS_TIME_US
    localparam int REF_FULL         = 200;
    localparam int SS_LOW_PCT       = 5;
    localparam int SS_HIGH_PCT      = 95;
    localparam int SS_TIME_US       = 750;
    localparam int SS_STEPS         = REF_FULL * (SS_HIGH_PCT - SS_LOW_PCT) / 100;
    localparam int SS_STEP_CYC      = SS_TIME_US * CLK_MHZ / SS_STEPS;

    // processor reset hold and warm reset filter
    localparam int RESET_HOLD_MS    = 100;
    localparam int RESET_HOLD_CYC   = RESET_HOLD_MS * 1000 * CLK_MHZ;
    localparam int DEBOUNCE_MS      = 30;
    localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * 1000 * CLK_MHZ;

    // default voltages in millivolts, strap low / strap high
    localparam logic [11:0] CORE_LO_MV   = 12'h514;   // 1300 mV
    localparam logic [11:0] CORE_HI_MV   = 12'h60e;   // 1550 mV
    localparam logic [11:0] MEMORY_LO_MV = 12'h708;   // 1800 mV
    localparam logic [11:0] MEMORY_HI_MV = 12'h9c4;   // 2500 mV
    localparam logic [11:0] SYSTEM_LO_MV = 12'hbb8;   // 3000 mV
    localparam logic [11:0] SYSTEM_HI_MV = 12'hce4;   // 3300 mV

    // register offsets
    localparam logic [3:0] REG_CONVERTER_CONTROL_2    = 4'h0;
    localparam logic [3:0] REG_LINEAR_REG_CONTROL     = 4'h1;
    localparam logic [3:0] REG_LINEAR_REG_VOLTAGE     = 4'h2;
    localparam logic [3:0] REG_CORE_VOLTAGE           = 4'h3;
    localparam logic [3:0] REG_POWER_GOOD_STATUS      = 4'h4;
    localparam logic [3:0] REG_BLOCK_STATE            = 4'h5;

    // reset values
    localparam logic [2:0]  DISCHARGE_RST   = 3'h0;
    localparam logic [1:0]  LINEAR_EN_RST   = 2'h3;
    localparam logic [7:0]  LINEAR_VOLT_RST = 8'h00;

    // block state register field positions
    localparam int ST_RUNNING_LSB   = 0;    // three bits, converter in run state, soft start done
    localparam int ST_LINEAR_LSB    = 3;    // two bits, linear regulators on
    localparam int ST_SHUTDOWN_BIT  = 5;
    localparam int ST_RESET_BIT     = 6;
    localparam int ST_WARM_BIT      = 7;

    // filtered pin vector positions
    localparam int PIN_CONV_LSB     = 0;    // three converter enables
    localparam int PIN_LINEAR_EN    = 3;
    localparam int PIN_UVLO         = 4;
    localparam int PIN_OVER_TEMPERATURE     = 5;
    localparam int PIN_BACKUP_GOOD  = 6;
    localparam int PIN_LOW_LSB      = 7;    // five rail-low comparators
    localparam int PIN_DROP_LSB     = 12;   // three dropout detectors
    localparam int PIN_STRAP_LSB    = 15;   // three default-select straps
    localparam int PIN_COUNT        = 18;

    typedef enum logic [1:0] {
        CONV_OFF  = 2'b00,
        CONV_BIAS = 2'b01,
        CONV_RAMP = 2'b10,
        CONV_RUN  = 2'b11
    } rerc_conv_state_t;

endpackage

// *** src/rerc_pin_filter.sv ***
// Purpose: synchroniser and stability filter
// Assumes: pin asynchronous to clk
// Notes:   stages two and three must agree STABLE_CYC cycles
`timescale 1ns/1ps
`default_nettype none
module rerc_pin_filter #(
    parameter int   STABLE_CYC = 1,
    parameter logic INIT       = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin and accepted level
    input  wire logic pinIn,
    output logic      pinOut
);
    logic        sync1_ff;
    logic        sync2_ff;
    logic        sync3_ff;
    logic        level_ff;
    logic [19:0] stable_ff;

    // synchroniser chain; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff <= INIT;
            sync2_ff <= INIT;
            sync3_ff <= INIT;
        end else begin
            sync1_ff <= pinIn;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a bounce restarts the count, so only a quiet pin gets through
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level_ff  <= INIT;
            stable_ff <= 20'h00000;
        end else if (sync2_ff != sync3_ff || sync3_ff == level_ff) begin
            stable_ff <= 20'h00000;
        end else if (stable_ff == 20'(STABLE_CYC - 1)) begin
            level_ff  <= sync3_ff;
            stable_ff <= 20'h00000;
        end else begin
            stable_ff <= stable_ff + 20'h00001;
        end
    end

    assign pinOut = level_ff;
endmodule
`default_nettype wire

// *** tb/rerc_host_model.sv ***
// Purpose: host side pins
// Assumes: level requests
// Notes:   released warm reset reads high
`timescale 1ns/1ps
`default_nettype none
module rerc_host_model (
    // requests
    input  wire logic [2:0] convReq,
    input  wire logic       linReq,
    input  wire logic       warmPress,
    // pins
    output logic            systemConvEnable,
    output logic            memoryConvEnable,
    output logic            coreConvEnable,
    output logic            linearRegEnable,
    output logic            warmResetInN
);
    // one pin per converter, any order, high enables
    assign {coreConvEnable, memoryConvEnable, systemConvEnable} = convReq;
    assign linearRegEnable = linReq;
    // pull-up wins when idle
    assign warmResetInN = warmPress ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// *** tb/rerc_checker.sv ***
// Purpose: port-level properties
// Assumes: one clock domain
// Notes:   repetitions cover pin sync delay
`timescale 1ns/1ps
`default_nettype none
module rerc_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // pins
    input wire logic       supplyUndervoltage,
    input wire logic       backupRailGood,
    input wire logic [4:0] railBelowTarget,
    // outputs
    input wire logic [2:0] convBiasOn,
    input wire logic [2:0] convSwitchOn,
    input wire logic [2:0] convLowSideBlock,
    input wire logic [2:0] convFullDuty,
    input wire logic [2:0] convDischarge,
    input wire logic [1:0] linearRegOn,
    input wire logic       powerFaultIrq,
    input wire logic       processorResetOutO,
    input wire logic       processorResetOutOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    drain_only_a: assert property (!processorResetOutO) else $error("pin high");
    backup_low_a: assert property (!backupRailGood [*6] |-> processorResetOutOe)
        else $error("no reset");
    hold_start_a: assert property ($rose(backupRailGood) |-> processorResetOutOe [*8])
        else $error("short hold");
    bias_first_a: assert property ($rose(convSwitchOn[2]) |-> $past(convBiasOn[2], 3399))
        else $error("early switch");
    ramp_block_a: assert property ((convLowSideBlock & ~convSwitchOn) == 3'h0)
        else $error("stray block");
    full_duty_a: assert property ((convFullDuty & ~convSwitchOn) == 3'h0)
        else $error("stray duty");
    drain_off_a: assert property ((convDischarge & convBiasOn) == 3'h0)
        else $error("stray drain");
    lockout_on_a: assert property (supplyUndervoltage [*6] |->
        convBiasOn == 3'h0 && linearRegOn == 2'h0)
        else $error("on in lockout");
    quiet_irq_a: assert property ((railBelowTarget == 5'h00) [*6] |-> !powerFaultIrq)
        else $error("stray irq");
endmodule
bind rerc_regulator_enable_reset_control rerc_checker chk_i (.*);
`default_nettype wire

// *** tb/regulator_enable_reset_control_tb.sv ***
// Purpose: self-checking bench
// Assumes: hold 20, debounce 8 cycles
// Notes:   bias and ramp at full length
`timescale 1ns/1ps
`default_nettype none
module regulator_enable_reset_control_tb;
    logic        clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, linReq = 1'b1;
    logic        press = 1'b0, supplyUndervoltage = 1'b0, overTemperature = 1'b0;
    logic        backupRailGood = 1'b1, powerFaultIrq, processorResetOutOe, warmResetInN;
    logic        systemConvEnable, memoryConvEnable, coreConvEnable, linearRegEnable;
    logic [2:0]  convReq = 3'h0, strap = 3'h0, dropoutDetect = 3'h0, convBiasOn, convSwitchOn;
    logic [2:0]  convFullDuty, convDischarge;
    logic [4:0]  railBelowTarget = 5'h00;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000, regRdata;
    logic [11:0] systemRail, memoryRail, coreRail;
    logic [7:0]  coreSoftStartRef;
    logic [1:0]  linearRegOn;
    int          err_total = 0, compares = 0, cyc = 0;
    always #25 clk = ~clk;
    rerc_host_model host (.convReq, .linReq, .warmPress(press), .systemConvEnable,
        .memoryConvEnable, .coreConvEnable, .linearRegEnable, .warmResetInN);
    rerc_regulator_enable_reset_control #(.RESET_HOLD_CYC(24'd20), .DEBOUNCE_CYC(8)) dut (
        .clk, .rst_n, .systemConvEnable, .memoryConvEnable, .coreConvEnable, .linearRegEnable,
        .systemDefaultSelect(strap[0]), .memoryDefaultSelect(strap[1]),
        .coreDefaultSelect(strap[2]), .supplyUndervoltage, .overTemperature, .backupRailGood,
        .railBelowTarget, .dropoutDetect, .systemPrecharge(8'h00), .memoryPrecharge(8'h00),
        .corePrecharge(8'h00), .warmResetInN, .warmResetPullupEn(), .convBiasOn, .convSwitchOn,
        .convLowSideBlock(), .convFullDuty, .convDischarge, .systemSoftStartRef(),
        .memorySoftStartRef(), .coreSoftStartRef, .systemRail, .memoryRail, .coreRail,
        .linearRegOn, .linearRegVoltage(), .powerFaultIrq, .processorResetOutO(),
        .processorResetOutOe, .regAddr, .regWdata, .regWrite, .regRead, .regRdata);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk) regWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk) regRead <= 1'b0;
        @(negedge clk) chk(regRdata, exp);
        @(posedge clk);
    endtask
    task automatic t_regs;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0003);
        rd(4'hf, 16'h0000);
        wr(4'h0, 16'h0007);
        wr(4'h1, 16'h0000);
        @(negedge clk) chk(16'(convDischarge), 16'h0007);
        chk(16'(linearRegOn), 16'h0000);
        @(posedge clk) wr(4'h1, 16'h0003);
    endtask
    task automatic t_straps;
        for (int s = 0; s < 2; s++) begin
            strap <= {3{s[0]}};
            repeat (6) @(posedge clk);
            chk(16'(systemRail), s ? rerc_pkg::SYSTEM_HI_MV : rerc_pkg::SYSTEM_LO_MV);
            chk(16'(memoryRail), s ? rerc_pkg::MEMORY_HI_MV : rerc_pkg::MEMORY_LO_MV);
            chk(16'(coreRail), s ? rerc_pkg::CORE_HI_MV : rerc_pkg::CORE_LO_MV);
        end
    endtask
    // core converter life cycle
    task automatic t_conv;
        int n;
        convReq <= 3'h4;
        repeat (3000) @(posedge clk);
        chk(16'(convBiasOn), 16'h0004);
        chk(16'(convSwitchOn), 16'h0000);
        n = 0;
        while (coreSoftStartRef !== 8'hc8 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk(16'(n > 16995 && n < 17015), 16'h0001);
        dropoutDetect <= 3'h4;
        railBelowTarget <= 5'h04;
        repeat (6) @(posedge clk);
        chk(16'(convFullDuty), 16'h0004);
        chk(16'(powerFaultIrq), 16'h0001);
        rd(4'h4, 16'h0004);
        convReq <= 3'h0;
        repeat (6) @(posedge clk);
        chk(16'(convDischarge), 16'h0007);
        chk(16'(powerFaultIrq), 16'h0000);
        rd(4'h4, 16'h0000);
        railBelowTarget <= 5'h00;
        dropoutDetect <= 3'h0;
    endtask
    task automatic t_lockout;
        convReq <= 3'h1;
        for (int k = 0; k < 2; k++) begin
            repeat (10) @(posedge clk);
            {overTemperature, supplyUndervoltage} <= 2'(k + 1);
            repeat (6) @(posedge clk);
            chk(16'({convBiasOn, linearRegOn}), 16'h0000);
            {overTemperature, supplyUndervoltage} <= 2'h0;
        end
        convReq <= 3'h0;
    endtask
    task automatic t_reset;
        int n;
        backupRailGood <= 1'b0;
        repeat (6) @(posedge clk);
        chk(16'(processorResetOutOe), 16'h0001);
        backupRailGood <= 1'b1;
        n = 0;
        while (processorResetOutOe !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(16'(n > 21 && n < 28), 16'h0001);
        wr(4'h3, 16'h03e8);
        press <= 1'b1;
        repeat (4) @(posedge clk);
        press <= 1'b0;
        repeat (20) @(posedge clk);
        chk(16'({processorResetOutOe, coreRail}), 16'h03e8);
        press <= 1'b1;
        repeat (20) @(posedge clk);
        chk(16'(processorResetOutOe), 16'h0001);
        chk(16'(coreRail), 16'(rerc_pkg::CORE_HI_MV));
        rd(4'h0, 16'h0007);
        press <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            wrap_up;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(16'(processorResetOutOe), 16'h0001);
        t_regs;
        t_straps;
        t_conv;
        t_lockout;
        t_reset;
        wrap_up;
    end
endmodule
`default_nettype wire
